//--- bench/fault_monitor_chk.sv
`timescale 1ns/1ps
module fault_monitor_chk #(
  parameter int STORE_CYCLES = 20,
  parameter int WDOG_CYCLES = 50
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic fault_reset_input,
  input wire logic ram_check_error,
  input wire logic nv_write_error,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata_ff,
  input wire logic command_feedback_warning_ff,
  input wire logic processor_fault_ff,
  input wire logic ram_integrity_fault_ff,
  input wire logic nonvolatile_integrity_fault_ff,
  input wire logic nv_backup_req_ff,
  input wire logic nv_store_req_ff,
  input wire logic nv_init_req_ff,
  input wire logic nv_busy_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic cmd_wr = wr_stb && clk_en && addr == fault_monitor_pkg::REG_CMD;
  property p_rdata_idle;
    clk_en && !rd_stb |=> rdata_ff == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_warn_hold;
    command_feedback_warning_ff && !fault_reset_input && !(cmd_wr && wdata[0])
      |=> command_feedback_warning_ff;
  endproperty
  a_warn_hold: assert property (p_warn_hold) else $error("warning dropped");
  property p_cpu_hold;
    processor_fault_ff |=> processor_fault_ff;
  endproperty
  a_cpu_hold: assert property (p_cpu_hold) else $error("processor fault dropped");
  property p_ram_set;
    ram_check_error && clk_en |=> ram_integrity_fault_ff;
  endproperty
  a_ram_set: assert property (p_ram_set) else $error("ram fault not set");
  property p_nv_set;
    nv_write_error && clk_en |=> nonvolatile_integrity_fault_ff;
  endproperty
  a_nv_set: assert property (p_nv_set) else $error("nv fault not set");
  property p_ram_block;
    $past(ram_integrity_fault_ff) |-> !nv_backup_req_ff && !nv_store_req_ff;
  endproperty
  a_ram_block: assert property (p_ram_block) else $error("backup in ram fault");
  property p_store;
    nv_store_req_ff |-> nv_busy_ff ##1 (nv_busy_ff && !nv_store_req_ff);
  endproperty
  a_store: assert property (p_store) else $error("store pulse malformed");
  property p_init_refuse;
    cmd_wr && wdata[2] && !nonvolatile_integrity_fault_ff |=> !nv_init_req_ff;
  endproperty
  a_init_refuse: assert property (p_init_refuse) else $error("init not refused");
endmodule // fault_monitor_chk

bind servo_drive_fault_monitor fault_monitor_chk #(
  .STORE_CYCLES(STORE_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)
) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .fault_reset_input(fault_reset_input),
  .ram_check_error(ram_check_error), .nv_write_error(nv_write_error), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff),
  .command_feedback_warning_ff(command_feedback_warning_ff),
  .processor_fault_ff(processor_fault_ff), .ram_integrity_fault_ff(ram_integrity_fault_ff),
  .nonvolatile_integrity_fault_ff(nonvolatile_integrity_fault_ff),
  .nv_backup_req_ff(nv_backup_req_ff), .nv_store_req_ff(nv_store_req_ff),
  .nv_init_req_ff(nv_init_req_ff), .nv_busy_ff(nv_busy_ff)
);

//--- bench/host_pulse_model.sv
`timescale 1ns/1ps
module host_pulse_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] cmd_per,
  input wire logic [15:0] fb_per,
  output logic cmd_pulse,
  output logic fb_pulse
);
  logic [15:0] cmd_cnt_ff;
  logic [15:0] fb_cnt_ff;
  // one high cycle per period, period zero keeps the line low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_cnt_ff <= 16'h0;
      cmd_pulse <= 1'b0;
    end else begin
      cmd_cnt_ff <= (cmd_cnt_ff + 16'h1 >= cmd_per) ? 16'h0 : cmd_cnt_ff + 16'h1;
      cmd_pulse <= (cmd_per != 16'h0) && (cmd_cnt_ff == 16'h0);
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_cnt_ff <= 16'h0;
      fb_pulse <= 1'b0;
    end else begin
      fb_cnt_ff <= (fb_cnt_ff + 16'h1 >= fb_per) ? 16'h0 : fb_cnt_ff + 16'h1;
      fb_pulse <= (fb_per != 16'h0) && (fb_cnt_ff == 16'h0);
    end
  end
endmodule // host_pulse_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, fri = 1'b0, hb = 1'b0, hb_en = 1'b1;
  logic rce = 1'b0, nwe = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] a = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [15:0] cmd_per = 16'h0, fb_per = 16'h0;
  logic [31:0] rdata_ff;
  logic warn, cpu_f, ram_f, nv_f, bk, st, ini, busy, irq, cmd_pulse, fb_pulse;
  logic [31:0] frv [3] = '{32'h3e8, 32'h0, 32'hffff};
  logic [31:0] vlv [3] = '{32'h8fc, 32'hfff, 32'h23};
  logic [31:0] ppr_def = 32'(fault_monitor_pkg::PPR_RST), fr_def = 32'(fault_monitor_pkg::FR_RST);
  int failures = 0;
  int tests_run = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (hb_en) hb <= ~hb;
  host_pulse_model u_host (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_per(cmd_per),
    .fb_per(fb_per), .cmd_pulse(cmd_pulse), .fb_pulse(fb_pulse));
  servo_drive_fault_monitor #(.STORE_CYCLES(20), .WDOG_CYCLES(50)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_pulse(cmd_pulse),
    .fb_pulse(fb_pulse), .fault_reset_input(fri), .cpu_heartbeat(hb), .ram_check_error(rce),
    .nv_write_error(nwe), .addr(a), .wdata(wd), .wr_stb(wr), .rd_stb(rd), .rdata_ff(rdata_ff),
    .command_feedback_warning_ff(warn), .processor_fault_ff(cpu_f),
    .ram_integrity_fault_ff(ram_f), .nonvolatile_integrity_fault_ff(nv_f),
    .nv_backup_req_ff(bk), .nv_store_req_ff(st), .nv_init_req_ff(ini), .nv_busy_ff(busy),
    .irq_ff(irq));
  task automatic close_out();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] ad, input logic [31:0] e, input string n);
    @(posedge ref_clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata_ff);
  endtask
  // one high cycle on a fault input: 0 reset input, 1 nv error, 2 ram error
  task automatic pin_pulse(input int sel);
    @(posedge ref_clk);
    if (sel == 0) fri <= 1'b1;
    else if (sel == 1) nwe <= 1'b1;
    else rce <= 1'b1;
    @(posedge ref_clk);
    fri <= 1'b0;
    nwe <= 1'b0;
    rce <= 1'b0;
    cyc(1);
  endtask
  // pulses run until the warning shows, then stop and clear it
  task automatic sub_case(input logic [15:0] cp, fp, input logic [3:0] sub, input logic ie,
      input logic via_cmd);
    logic [3:0] slot;
    logic [31:0] entry;
    slot = (sub == 4'h0) ? 4'h0 : 4'h3 - sub;
    entry = {24'h0, fault_monitor_pkg::CODE_CMDFB, sub};
    cmd_per <= cp;
    fb_per <= fp;
    for (int i = 0; i < 12500 && warn !== 1'b1; i++) cyc(1);
    if (warn !== 1'b1) begin
      failures++;
      close_out();
    end
    rd_reg(fault_monitor_pkg::REG_FAULT, 32'h1 | (32'h10 << sub), "fault word");
    chk("irq level", {31'h0, ie}, {31'h0, irq});
    rd_reg(fault_monitor_pkg::REG_IRQ_STAT, 32'h1, "irq status");
    cyc(1);
    chk("irq after read", 32'h0, {31'h0, irq});
    wr_reg(fault_monitor_pkg::REG_HIST_SEL, {28'h0, slot});
    rd_reg(fault_monitor_pkg::REG_HIST_DATA, entry, "history entry");
    cmd_per <= 16'h0;
    fb_per <= 16'h0;
    cyc(5100);
    chk("warning held", 32'h1, {31'h0, warn});
    if (via_cmd) wr_reg(fault_monitor_pkg::REG_CMD, 32'h1);
    else pin_pulse(0);
    chk("warning cleared", 32'h0, {31'h0, warn});
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(fault_monitor_pkg::REG_PPR, ppr_def, "ppr reset");
    rd_reg(fault_monitor_pkg::REG_VL, 32'h231, "vl reset");
    rd_reg(4'hb, 32'h0, "unmapped");
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr_reg(fault_monitor_pkg::REG_PPR, 32'h5);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd_reg(fault_monitor_pkg::REG_PPR, ppr_def, "ppr frozen");
    for (int i = 0; i < 3; i++) begin
      wr_reg(fault_monitor_pkg::REG_FR, frv[i]);
      chk("backup pulse", 32'h1, {31'h0, bk});
      rd_reg(fault_monitor_pkg::REG_VL, vlv[i], "vl recomputed");
    end
    wr_reg(fault_monitor_pkg::REG_CTRL, 32'h1);
    wr_reg(fault_monitor_pkg::REG_PPR, 32'h64);
    chk("backup locked", 32'h0, {31'h0, bk});
    wr_reg(fault_monitor_pkg::REG_CTRL, 32'h0);
    wr_reg(fault_monitor_pkg::REG_VL, 32'h231);
    wr_reg(fault_monitor_pkg::REG_CMD, 32'h4);
    chk("init refused", 32'h0, {31'h0, ini});
    wr_reg(fault_monitor_pkg::REG_CMD, 32'h2);
    chk("store request", 32'h1, {31'h0, st});
    rd_reg(fault_monitor_pkg::REG_CMD, 32'h1, "busy bit");
    for (int i = 0; i < 40 && busy !== 1'b0; i++) cyc(1);
    chk("store done", 32'h0, {31'h0, busy});
    rd_reg(fault_monitor_pkg::REG_IRQ_STAT, 32'h10, "store irq");
    wr_reg(fault_monitor_pkg::REG_IRQ_MASK, 32'h1);
    sub_case(16'h7d0, 16'h0, 4'h0, 1'b1, 1'b0);
    wr_reg(fault_monitor_pkg::REG_IRQ_MASK, 32'h0);
    sub_case(16'h0, 16'h4, 4'h2, 1'b0, 1'b1);
    wr_reg(fault_monitor_pkg::REG_PPR, 32'hfffff);
    wr_reg(fault_monitor_pkg::REG_VL, 32'h1);
    cmd_per <= 16'h4;
    cyc(22500);
    chk("warning early", 32'h0, {31'h0, warn});
    sub_case(16'h4, 16'h0, 4'h1, 1'b0, 1'b0);
    rd_reg(fault_monitor_pkg::REG_HIST_CNT, 32'h3, "history count");
    pin_pulse(1);
    chk("nv fault", 32'h1, {31'h0, nv_f});
    wr_reg(fault_monitor_pkg::REG_CMD, 32'h4);
    chk("init accepted", 32'h1, {31'h0, ini});
    rd_reg(fault_monitor_pkg::REG_PPR, ppr_def, "ppr default");
    pin_pulse(2);
    chk("ram fault", 32'h1, {31'h0, ram_f});
    wr_reg(fault_monitor_pkg::REG_PPR, 32'h9);
    chk("backup blocked", 32'h0, {31'h0, bk});
    wr_reg(fault_monitor_pkg::REG_CMD, 32'h2);
    chk("store blocked", 32'h0, {31'h0, st});
    rd_reg(fault_monitor_pkg::REG_FR, fr_def, "fr readable");
    hb_en <= 1'b0;
    cyc(60);
    chk("cpu fault", 32'h1, {31'h0, cpu_f});
    rd_reg(fault_monitor_pkg::REG_FAULT, 32'he, "faults latched");
    close_out();
  end
endmodule // tb_top

//--- verilog/alarm_history_mem.sv
`timescale 1ns/1ps
module alarm_history_mem (
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [fault_monitor_pkg::HIST_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [fault_monitor_pkg::HIST_AW-1:0] rd_addr,
  output logic [7:0] rd_data_ff
);
  logic [7:0] mem [0:(1<<fault_monitor_pkg::HIST_AW)-1];

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
    end
  end
endmodule // alarm_history_mem

//--- verilog/fault_monitor_pkg.sv
package fault_monitor_pkg;
  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int WINDOW_NS = 100_000;
  localparam int WINDOW_CYC = (WINDOW_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int WINDOWS_PER_S = 1_000_000_000 / WINDOW_NS;
  localparam int SUSTAIN_NS = 1_000_000;
  localparam int SUSTAIN_WINDOWS = SUSTAIN_NS / WINDOW_NS;
  localparam int VEL_MAX_RPS = 30;
  localparam int FB_LIMIT_HZ = 2_300_000;
  localparam int FB_LIMIT_CNT = FB_LIMIT_HZ / WINDOWS_PER_S;
  localparam int STORE_S = 30;
  localparam int STORE_CYC = STORE_S * CLK_HZ;
  localparam int WDOG_MS = 10;
  localparam int WDOG_CYC = WDOG_MS * (CLK_HZ / 1000);

  // widths
  localparam int CNT_W = 16;
  localparam int PPR_W = 20;
  localparam int FR_W = 16;
  localparam int VL_W = 12;
  localparam int HIST_AW = 4;

  // register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_PPR = 4'h2;
  localparam logic [3:0] REG_FR = 4'h3;
  localparam logic [3:0] REG_VL = 4'h4;
  localparam logic [3:0] REG_FAULT = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK = 4'h7;
  localparam logic [3:0] REG_HIST_SEL = 4'h8;
  localparam logic [3:0] REG_HIST_DATA = 4'h9;
  localparam logic [3:0] REG_HIST_CNT = 4'ha;

  // field positions
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_STORE_BIT = 1;
  localparam int CMD_INIT_BIT = 2;
  localparam int EVT_W = 5;
  localparam int EVT_CMDFB = 0;
  localparam int EVT_CPU = 1;
  localparam int EVT_RAM = 2;
  localparam int EVT_NV = 3;
  localparam int EVT_STORE_DONE = 4;

  // alarm history codes
  localparam logic [3:0] CODE_CMDFB = 4'h1;
  localparam logic [3:0] CODE_CPU = 4'h2;
  localparam logic [3:0] CODE_RAM = 4'h3;
  localparam logic [3:0] CODE_NV = 4'h4;

  // reset values
  localparam logic [PPR_W-1:0] PPR_RST = 20'h01000;
  localparam logic [FR_W-1:0] FR_RST = 16'h1000;
  localparam logic [VL_W-1:0] VL_RST = VL_W'(FB_LIMIT_HZ / 4096);
  localparam logic [EVT_W-1:0] MASK_RST = 5'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_STORE = 2'b10
  } store_state_type;
endpackage

//--- verilog/rate_window.sv
`timescale 1ns/1ps
module rate_window (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pulse,
  output logic [fault_monitor_pkg::CNT_W-1:0] count_ff,
  output logic done_ff
);
  logic prev_ff;
  logic [15:0] tick_ff;
  logic [fault_monitor_pkg::CNT_W-1:0] acc_ff;
  logic rise;
  logic last;

  assign rise = pulse & ~prev_ff;
  assign last = (tick_ff == 16'(fault_monitor_pkg::WINDOW_CYC - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
      tick_ff <= 16'h0000;
      acc_ff <= '0;
      count_ff <= '0;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      prev_ff <= pulse;
      done_ff <= last;
      if (last) begin
        tick_ff <= 16'h0000;
        count_ff <= acc_ff + {{(fault_monitor_pkg::CNT_W-1){1'b0}}, rise};
        acc_ff <= '0;
      end else begin
        tick_ff <= tick_ff + 16'h0001;
        if (rise && acc_ff != '1) begin
          acc_ff <= acc_ff + 1'b1;
        end
      end
    end
  end
endmodule // rate_window

//--- verilog/servo_drive_fault_monitor.sv
`timescale 1ns/1ps
// How it works
// - raise command/feedback warning on excessive command velocity or feedback rate
// - log sub-cause in alarm history; fault log query reads it back
// - command velocity is pulse rate over pulses per revolution
// - sub-cause 0 when command velocity exceeds 30 rev/s
// - sub-cause 1 when command exceeds 1.5x ceiling for over 1 ms
// - sub-cause 2 when feedback pulse rate exceeds 2.3 MHz
// - writing feedback resolution recomputes the velocity ceiling
// - warning holds until fault reset input or fault reset command
// - raise processor fault when the processor stops working
// - raise working memory fault when held data is corrupted
// - no nonvolatile backup while working memory fault is active
// - settings stay readable during working memory fault
// - raise nonvolatile fault when a store or rewrite fails
// - write lock stops automatic nonvolatile backup
// - explicit store writes settings, lasting about 30 seconds
// - restore defaults during nonvolatile fault reinitialises settings
module servo_drive_fault_monitor #(
  parameter int STORE_CYCLES = fault_monitor_pkg::STORE_CYC,
  parameter int WDOG_CYCLES = fault_monitor_pkg::WDOG_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cmd_pulse,
  input wire logic fb_pulse,
  input wire logic fault_reset_input,
  input wire logic cpu_heartbeat,
  input wire logic ram_check_error,
  input wire logic nv_write_error,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata_ff,
  output logic command_feedback_warning_ff,
  output logic processor_fault_ff,
  output logic ram_integrity_fault_ff,
  output logic nonvolatile_integrity_fault_ff,
  output logic nv_backup_req_ff,
  output logic nv_store_req_ff,
  output logic nv_init_req_ff,
  output logic nv_busy_ff,
  output logic irq_ff
);
  // velocity check: cnt per window * windows/s * den > num * ppr * scale
  function automatic logic over_rate(
    input logic [fault_monitor_pkg::CNT_W-1:0] cnt,
    input logic [47:0] limit_x_ppr,
    input logic [1:0] den
  );
    logic [47:0] lhs;
    lhs = 48'(cnt) * 48'(fault_monitor_pkg::WINDOWS_PER_S) * 48'(den);
    over_rate = lhs > limit_x_ppr;
  endfunction

  function automatic logic [fault_monitor_pkg::VL_W-1:0] auto_ceiling(
    input logic [fault_monitor_pkg::FR_W-1:0] fr
  );
    logic [31:0] q;
    q = (fr == '0) ? 32'hffffffff : 32'(fault_monitor_pkg::FB_LIMIT_HZ) / 32'(fr);
    if (q > 32'(2 ** fault_monitor_pkg::VL_W - 1)) begin
      auto_ceiling = '1;
    end else if (q == 32'h00000000) begin
      auto_ceiling = fault_monitor_pkg::VL_W'(1);
    end else begin
      auto_ceiling = q[fault_monitor_pkg::VL_W-1:0];
    end
  endfunction

  logic [fault_monitor_pkg::CNT_W-1:0] cmd_cnt;
  logic cmd_done;
  logic [fault_monitor_pkg::CNT_W-1:0] fb_cnt;
  logic fb_done;
  logic [7:0] hist_rd;

  logic lock_ff;
  logic [fault_monitor_pkg::PPR_W-1:0] ppr_ff;
  logic [fault_monitor_pkg::FR_W-1:0] fr_ff;
  logic [fault_monitor_pkg::VL_W-1:0] vl_ff;
  logic [fault_monitor_pkg::EVT_W-1:0] irq_stat_ff;
  logic [fault_monitor_pkg::EVT_W-1:0] irq_mask_ff;
  logic [fault_monitor_pkg::HIST_AW-1:0] hist_sel_ff;
  logic [fault_monitor_pkg::HIST_AW-1:0] hist_wp_ff;
  logic [fault_monitor_pkg::HIST_AW:0] hist_cnt_ff;
  logic [2:0] sub_seen_ff;
  logic [3:0] sustain_ff;
  logic hb_prev_ff;
  logic [31:0] wdog_ff;
  logic [31:0] store_cnt_ff;
  fault_monitor_pkg::store_state_type state_ff;
  fault_monitor_pkg::store_state_type nxt_state;

  logic wr_ctrl, wr_cmd, wr_ppr, wr_fr, wr_vl;
  logic clear_req, store_cmd, init_cmd, init_go, settings_wr;
  logic [2:0] sub_hit, sub_new;
  logic [47:0] lim0, lim1;
  logic cpu_set, ram_set, nv_set, store_done;
  logic [fault_monitor_pkg::EVT_W-1:0] events;
  logic hist_we;
  logic [7:0] hist_wd;

  rate_window u_cmd_rate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pulse(cmd_pulse),
    .count_ff(cmd_cnt),
    .done_ff(cmd_done)
  );

  rate_window u_fb_rate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pulse(fb_pulse),
    .count_ff(fb_cnt),
    .done_ff(fb_done)
  );

  alarm_history_mem u_hist (
    .ref_clk(ref_clk),
    .clk_en(clk_en),
    .wr_en(hist_we),
    .wr_addr(hist_wp_ff),
    .wr_data(hist_wd),
    .rd_addr(hist_sel_ff),
    .rd_data_ff(hist_rd)
  );

  assign wr_ctrl = wr_stb && addr == fault_monitor_pkg::REG_CTRL;
  assign wr_cmd = wr_stb && addr == fault_monitor_pkg::REG_CMD;
  assign wr_ppr = wr_stb && addr == fault_monitor_pkg::REG_PPR;
  assign wr_fr = wr_stb && addr == fault_monitor_pkg::REG_FR;
  assign wr_vl = wr_stb && addr == fault_monitor_pkg::REG_VL;
  assign clear_req = fault_reset_input
      || (wr_cmd && wdata[fault_monitor_pkg::CMD_CLEAR_BIT]);
  assign store_cmd = wr_cmd && wdata[fault_monitor_pkg::CMD_STORE_BIT];
  assign init_cmd = wr_cmd && wdata[fault_monitor_pkg::CMD_INIT_BIT];
  assign init_go = init_cmd && nonvolatile_integrity_fault_ff;
  assign settings_wr = wr_ppr || wr_fr || wr_vl;

  // command velocity in rev/s is cmd_cnt * windows/s / ppr
  assign lim0 = 48'(fault_monitor_pkg::VEL_MAX_RPS) * 48'(ppr_ff);
  assign lim1 = 48'(3) * 48'(vl_ff) * 48'(ppr_ff);
  assign sub_hit[0] = cmd_done && over_rate(cmd_cnt, lim0, 2'd1);
  assign sub_hit[1] = cmd_done && over_rate(cmd_cnt, lim1, 2'd2)
      && sustain_ff == 4'(fault_monitor_pkg::SUSTAIN_WINDOWS);
  assign sub_hit[2] = fb_done
      && fb_cnt > fault_monitor_pkg::CNT_W'(fault_monitor_pkg::FB_LIMIT_CNT);
  assign sub_new = sub_hit & ~sub_seen_ff;

  assign cpu_set = !processor_fault_ff && wdog_ff >= 32'(WDOG_CYCLES - 1);
  assign ram_set = ram_check_error && !ram_integrity_fault_ff;
  assign nv_set = nv_write_error && !nonvolatile_integrity_fault_ff;
  assign store_done = state_ff == fault_monitor_pkg::ST_STORE
      && store_cnt_ff >= 32'(STORE_CYCLES - 1);

  assign events = {store_done, nv_set, ram_set, cpu_set, |sub_new};

  // one history entry per cycle; lowest new event wins the slot
  always_comb begin
    hist_we = 1'b1;
    hist_wd = 8'h00;
    if (sub_new[0]) begin
      hist_wd = {fault_monitor_pkg::CODE_CMDFB, 4'h0};
    end else if (sub_new[1]) begin
      hist_wd = {fault_monitor_pkg::CODE_CMDFB, 4'h1};
    end else if (sub_new[2]) begin
      hist_wd = {fault_monitor_pkg::CODE_CMDFB, 4'h2};
    end else if (cpu_set) begin
      hist_wd = {fault_monitor_pkg::CODE_CPU, 4'h0};
    end else if (ram_set) begin
      hist_wd = {fault_monitor_pkg::CODE_RAM, 4'h0};
    end else if (nv_set) begin
      hist_wd = {fault_monitor_pkg::CODE_NV, 4'h0};
    end else begin
      hist_we = 1'b0;
    end
  end

  always_comb begin
    case (state_ff)
      fault_monitor_pkg::ST_IDLE: begin
        if (store_cmd && !ram_integrity_fault_ff) begin
          nxt_state = fault_monitor_pkg::ST_STORE;
        end else begin
          nxt_state = fault_monitor_pkg::ST_IDLE;
        end
      end
      fault_monitor_pkg::ST_STORE: begin
        nxt_state = store_done ? fault_monitor_pkg::ST_IDLE : fault_monitor_pkg::ST_STORE;
      end
      default: nxt_state = fault_monitor_pkg::ST_IDLE;
    endcase
  end

  // settings
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= 1'b0;
      ppr_ff <= fault_monitor_pkg::PPR_RST;
      fr_ff <= fault_monitor_pkg::FR_RST;
      vl_ff <= fault_monitor_pkg::VL_RST;
      irq_mask_ff <= fault_monitor_pkg::MASK_RST;
      hist_sel_ff <= '0;
    end else if (clk_en) begin
      if (init_go) begin
        ppr_ff <= fault_monitor_pkg::PPR_RST;
        fr_ff <= fault_monitor_pkg::FR_RST;
        vl_ff <= fault_monitor_pkg::VL_RST;
        lock_ff <= 1'b0;
      end else begin
        if (wr_ctrl) begin
          lock_ff <= wdata[fault_monitor_pkg::CTRL_LOCK_BIT];
        end
        if (wr_ppr) begin
          ppr_ff <= wdata[fault_monitor_pkg::PPR_W-1:0];
        end
        if (wr_fr) begin
          fr_ff <= wdata[fault_monitor_pkg::FR_W-1:0];
          vl_ff <= auto_ceiling(wdata[fault_monitor_pkg::FR_W-1:0]);
        end else if (wr_vl) begin
          vl_ff <= wdata[fault_monitor_pkg::VL_W-1:0];
        end
      end
      if (wr_stb && addr == fault_monitor_pkg::REG_IRQ_MASK) begin
        irq_mask_ff <= wdata[fault_monitor_pkg::EVT_W-1:0];
      end
      if (wr_stb && addr == fault_monitor_pkg::REG_HIST_SEL) begin
        hist_sel_ff <= wdata[fault_monitor_pkg::HIST_AW-1:0];
      end
    end
  end

  // command/feedback warning and its sustain counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_seen_ff <= 3'h0;
      sustain_ff <= 4'h0;
      command_feedback_warning_ff <= 1'b0;
    end else if (clk_en) begin
      if (cmd_done) begin
        if (!over_rate(cmd_cnt, lim1, 2'd2)) begin
          sustain_ff <= 4'h0;
        end else if (sustain_ff != 4'(fault_monitor_pkg::SUSTAIN_WINDOWS)) begin
          sustain_ff <= sustain_ff + 4'h1;
        end
      end
      // a new sub-cause in the clearing cycle survives the clear
      sub_seen_ff <= (clear_req ? 3'h0 : sub_seen_ff) | sub_hit;
      command_feedback_warning_ff <= (!clear_req && command_feedback_warning_ff)
          || |sub_hit;
    end
  end

  // processor watchdog
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_prev_ff <= 1'b0;
      wdog_ff <= 32'h00000000;
      processor_fault_ff <= 1'b0;
    end else if (clk_en) begin
      hb_prev_ff <= cpu_heartbeat;
      if (cpu_heartbeat != hb_prev_ff) begin
        wdog_ff <= 32'h00000000;
      end else if (!processor_fault_ff) begin
        wdog_ff <= wdog_ff + 32'h00000001;
      end
      if (cpu_set) begin
        processor_fault_ff <= 1'b1;
      end
    end
  end

  // memory integrity faults, cleared only by power reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_integrity_fault_ff <= 1'b0;
      nonvolatile_integrity_fault_ff <= 1'b0;
    end else if (clk_en) begin
      if (ram_set) begin
        ram_integrity_fault_ff <= 1'b1;
      end
      if (nv_set) begin
        nonvolatile_integrity_fault_ff <= 1'b1;
      end
    end
  end

  // nonvolatile backup control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= fault_monitor_pkg::ST_IDLE;
      store_cnt_ff <= 32'h00000000;
      nv_busy_ff <= 1'b0;
      nv_store_req_ff <= 1'b0;
      nv_backup_req_ff <= 1'b0;
      nv_init_req_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      nv_busy_ff <= nxt_state == fault_monitor_pkg::ST_STORE;
      nv_store_req_ff <= state_ff == fault_monitor_pkg::ST_IDLE
          && nxt_state == fault_monitor_pkg::ST_STORE;
      if (state_ff == fault_monitor_pkg::ST_STORE) begin
        store_cnt_ff <= store_cnt_ff + 32'h00000001;
      end else begin
        store_cnt_ff <= 32'h00000000;
      end
      nv_backup_req_ff <= settings_wr && !lock_ff
          && !ram_integrity_fault_ff
          && state_ff == fault_monitor_pkg::ST_IDLE;
      nv_init_req_ff <= init_go;
    end
  end

  // alarm history pointer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_wp_ff <= '0;
      hist_cnt_ff <= '0;
    end else if (clk_en && hist_we) begin
      hist_wp_ff <= hist_wp_ff + 1'b1;
      if (hist_cnt_ff != (fault_monitor_pkg::HIST_AW+1)'(1 << fault_monitor_pkg::HIST_AW)) begin
        hist_cnt_ff <= hist_cnt_ff + 1'b1;
      end
    end
  end

  // interrupt status, cleared by reading it; a new event wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      if (rd_stb && addr == fault_monitor_pkg::REG_IRQ_STAT) begin
        irq_stat_ff <= events;
      end else begin
        irq_stat_ff <= irq_stat_ff | events;
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // register read port; reads stay open under every fault
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (clk_en) begin
      rdata_ff <= 32'h00000000;
      if (rd_stb) begin
        case (addr)
          fault_monitor_pkg::REG_CTRL: rdata_ff <= {31'h0, lock_ff};
          fault_monitor_pkg::REG_CMD: rdata_ff <= {31'h0, nv_busy_ff};
          fault_monitor_pkg::REG_PPR: rdata_ff <= 32'(ppr_ff);
          fault_monitor_pkg::REG_FR: rdata_ff <= 32'(fr_ff);
          fault_monitor_pkg::REG_VL: rdata_ff <= 32'(vl_ff);
          fault_monitor_pkg::REG_FAULT: begin
            rdata_ff <= {25'h0, sub_seen_ff, nonvolatile_integrity_fault_ff,
                ram_integrity_fault_ff, processor_fault_ff, command_feedback_warning_ff};
          end
          fault_monitor_pkg::REG_IRQ_STAT: rdata_ff <= 32'(irq_stat_ff);
          fault_monitor_pkg::REG_IRQ_MASK: rdata_ff <= 32'(irq_mask_ff);
          fault_monitor_pkg::REG_HIST_SEL: rdata_ff <= 32'(hist_sel_ff);
          fault_monitor_pkg::REG_HIST_DATA: rdata_ff <= {24'h0, hist_rd};
          fault_monitor_pkg::REG_HIST_CNT: rdata_ff <= 32'(hist_cnt_ff);
          default: rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // servo_drive_fault_monitor
